//--- core/led_fault_ctrl.sv
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`include "led_fault_params.svh"

module led_fault_ctrl #(
  parameter int CHANNELS     = `NUM_CHANNELS,
  parameter int POR_WAKE_CYC = `POR_WAKE_CYC,
  parameter int HW_WAKE_CYC  = `HW_WAKE_CYC,
  parameter int SW_WAKE_CYC  = `SW_WAKE_CYC
) (
  input  wire logic                    I_CLOCK,
  input  wire logic                    I_RESET,
  input  wire logic                    I_CLK_EN,
  input  wire led_fault_pkg::bus_req_t I_BUS,
  output logic [7:0]                   O_RDATA,
  input  wire logic                    I_OE_N,
  input  wire logic                    I_RESET_PIN_N,
  input  wire logic                    I_OVERHEAT,
  input  wire logic                    I_SCL,
  input  wire logic                    I_SDA,
  input  wire logic [CHANNELS-1:0]     I_OPEN,
  input  wire logic [CHANNELS-1:0]     I_SHORT,
  output logic                         O_SDA_OUT,
  output logic                         O_SDA_OE,
  output logic [CHANNELS-1:0]          O_LED_ON,
  output logic                         O_LED_HIZ,
  output logic                         O_READY
);

  localparam int ASYNC_W = 5 + 2 * CHANNELS;
  localparam int WK_W    = $clog2(POR_WAKE_CYC + 1);
  localparam int RST_MIN = `RST_MIN_CYC;
  localparam int FAST    = `FAST_PWM_CYC;
  localparam int STEP_X2 = 2 * FAST / 256;
  localparam logic [ASYNC_W-1:0] ASYNC_RST = ASYNC_W'(5'h1B);

  // ========================================================================
  // Elaboration checks
  if (CHANNELS < 4 || CHANNELS > 16 || CHANNELS % 4 != 0) begin : g_chk_ch
    $error("CHANNELS must be 4, 8, 12 or 16");
  end
  if (HW_WAKE_CYC < 1 || SW_WAKE_CYC < 1 || HW_WAKE_CYC > POR_WAKE_CYC ||
      SW_WAKE_CYC > POR_WAKE_CYC) begin : g_chk_wake
    $error("wake counts must lie between 1 and POR_WAKE_CYC");
  end
  if (2 * FAST % 256 != 0 || FAST > 4095) begin : g_chk_pwm
    $error("PWM period does not split into 256 steps");
  end

  // ========================================================================
  // Pin synchronisers, change taken once stages two and three agree
  logic [ASYNC_W-1:0] async_in;
  logic [ASYNC_W-1:0] sync1_reg;
  logic [ASYNC_W-1:0] sync2_reg;
  logic [ASYNC_W-1:0] sync3_reg;
  logic [ASYNC_W-1:0] filt_reg;
  logic               oe_n_f;
  logic               rst_pin_n_f;
  logic               overheat_f;
  logic               scl_f;
  logic               sda_f;
  logic [CHANNELS-1:0] open_f;
  logic [CHANNELS-1:0] short_f;

  assign async_in = {I_SHORT, I_OPEN, I_SDA, I_SCL, I_OVERHEAT,
                     I_RESET_PIN_N, I_OE_N};

  // Three stage chain with agreement filter
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      sync1_reg <= ASYNC_RST;
      sync2_reg <= ASYNC_RST;
      sync3_reg <= ASYNC_RST;
      filt_reg  <= ASYNC_RST;
    end else if (I_CLK_EN) begin
      sync1_reg <= async_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      filt_reg  <= (sync2_reg & sync3_reg) |
                   (filt_reg & (sync2_reg ^ sync3_reg));
    end
  end

  assign oe_n_f      = filt_reg[0];
  assign rst_pin_n_f = filt_reg[1];
  assign overheat_f  = filt_reg[2];
  assign scl_f       = filt_reg[3];
  assign sda_f       = filt_reg[4];
  assign open_f      = filt_reg[5 +: CHANNELS];
  assign short_f     = filt_reg[5 + CHANNELS +: CHANNELS];

  // ========================================================================
  // Reset pin qualification and wake timer
  logic [8:0]      pin_cnt_reg;
  logic [WK_W-1:0] wake_reg;
  logic            hw_rst;
  logic            soft_reset_call;
  logic            soft_clr;

  assign hw_rst   = !rst_pin_n_f && (pin_cnt_reg == 9'(RST_MIN));
  assign soft_clr = hw_rst || soft_reset_call;
  assign O_READY  = (wake_reg == '0);

  // Low time of the reset pin
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      pin_cnt_reg <= 9'h000;
    end else if (I_CLK_EN) begin
      if (rst_pin_n_f) begin
        pin_cnt_reg <= 9'h000;
      end else if (pin_cnt_reg != 9'(RST_MIN)) begin
        pin_cnt_reg <= pin_cnt_reg + 9'h001;
      end
    end
  end

  // Busy time after each kind of reset
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      wake_reg <= WK_W'(POR_WAKE_CYC);
    end else if (I_CLK_EN) begin
      if (hw_rst) begin
        wake_reg <= WK_W'(HW_WAKE_CYC);
      end else if (soft_reset_call) begin
        wake_reg <= WK_W'(SW_WAKE_CYC);
      end else if (wake_reg != '0) begin
        wake_reg <= wake_reg - 1'b1;
      end
    end
  end

  // ========================================================================
  // General call receiver for the soft reset call
  led_fault_pkg::gc_state_t gc_state_reg;
  logic [3:0] gc_bits_reg;
  logic [7:0] gc_shift_reg;
  logic       ack_reg;
  logic       scl_q_reg;
  logic       sda_q_reg;
  logic       bus_start;
  logic       bus_stop;
  logic       scl_rise;
  logic       scl_fall;
  logic       byte_done;

  assign bus_start = scl_f && scl_q_reg && sda_q_reg && !sda_f;
  assign bus_stop  = scl_f && scl_q_reg && !sda_q_reg && sda_f;
  assign scl_rise  = scl_f && !scl_q_reg;
  assign scl_fall  = !scl_f && scl_q_reg;
  assign byte_done = scl_fall && (gc_bits_reg == 4'h8) && !ack_reg;
  assign soft_reset_call     = bus_stop && (gc_state_reg == led_fault_pkg::GC_ARMED);
  assign O_SDA_OUT = 1'b0;
  assign O_SDA_OE  = ack_reg;

  // Previous line levels
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
    end else if (I_CLK_EN) begin
      scl_q_reg <= scl_f;
      sda_q_reg <= sda_f;
    end
  end

  // Byte shifting, acknowledge decision and release
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      gc_state_reg <= led_fault_pkg::GC_IDLE;
      gc_bits_reg  <= 4'h0;
      gc_shift_reg <= 8'h00;
      ack_reg      <= 1'b0;
    end else if (I_CLK_EN) begin
      if (hw_rst || bus_stop) begin
        gc_state_reg <= led_fault_pkg::GC_IDLE;
        gc_bits_reg  <= 4'h0;
        ack_reg      <= 1'b0;
      end else if (bus_start) begin
        gc_state_reg <= led_fault_pkg::GC_ADDR;
        gc_bits_reg  <= 4'h0;
        ack_reg      <= 1'b0;
      end else if (scl_rise && gc_bits_reg != 4'h8 &&
                   gc_state_reg != led_fault_pkg::GC_IDLE &&
                   gc_state_reg != led_fault_pkg::GC_IGNORE) begin
        gc_shift_reg <= {gc_shift_reg[6:0], sda_f};
        gc_bits_reg  <= gc_bits_reg + 4'h1;
      end else if (scl_fall && gc_bits_reg == 4'h8 && ack_reg) begin
        ack_reg     <= 1'b0;
        gc_bits_reg <= 4'h0;
      end else if (byte_done) begin
        case (gc_state_reg)
          led_fault_pkg::GC_ADDR: begin
            if (gc_shift_reg == `GC_ADDR_BYTE) begin
              ack_reg      <= 1'b1;
              gc_state_reg <= led_fault_pkg::GC_DATA;
            end else begin
              gc_state_reg <= led_fault_pkg::GC_IGNORE;
            end
          end
          led_fault_pkg::GC_DATA: begin
            if (gc_shift_reg == `SOFT_RESET_CALL_BYTE) begin
              ack_reg      <= 1'b1;
              gc_state_reg <= led_fault_pkg::GC_ARMED;
            end else begin
              gc_state_reg <= led_fault_pkg::GC_IGNORE;
            end
          end
          default: begin
            gc_state_reg <= led_fault_pkg::GC_IGNORE;
          end
        endcase
      end
    end
  end

  // ========================================================================
  // Software registers
  logic       wr_ok;
  logic       clr_req;
  logic       dimblk_reg;
  logic [7:0] gduty_reg;
  logic [7:0] gperiod_reg;
  logic [2*CHANNELS-1:0] ldr_reg;
  logic [7:0] duty_reg [CHANNELS];
  logic [2*CHANNELS-1:0] fault_reg;
  logic [7:0] rd_next;

  assign wr_ok   = I_BUS.write && O_READY && !soft_clr;
  assign clr_req = wr_ok && (I_BUS.addr == `REG_SECOND_MODE_REGISTER) &&
                   I_BUS.wdata[`SECOND_MODE_REGISTER_CLR_FAULT];

  // Register writes, cleared by pin or soft reset
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      dimblk_reg  <= 1'b0;
      gduty_reg   <= 8'h00;
      gperiod_reg <= 8'h00;
      ldr_reg     <= '0;
      for (int k = 0; k < CHANNELS; k++) begin
        duty_reg[k] <= 8'h00;
      end
    end else if (I_CLK_EN) begin
      if (soft_clr) begin
        dimblk_reg  <= 1'b0;
        gduty_reg   <= 8'h00;
        gperiod_reg <= 8'h00;
        ldr_reg     <= '0;
        for (int k = 0; k < CHANNELS; k++) begin
          duty_reg[k] <= 8'h00;
        end
      end else if (wr_ok) begin
        if (I_BUS.addr == `REG_SECOND_MODE_REGISTER) begin
          dimblk_reg <= I_BUS.wdata[`SECOND_MODE_REGISTER_DIMBLK];
        end
        if (I_BUS.addr == `REG_GROUP_DUTY) begin
          gduty_reg <= I_BUS.wdata;
        end
        if (I_BUS.addr == `REG_GROUP_PERIOD) begin
          gperiod_reg <= I_BUS.wdata;
        end
        for (int k = 0; k < CHANNELS / 4; k++) begin
          if (I_BUS.addr == 8'(int'(`REG_LDR_BASE) + k)) begin
            ldr_reg[8*k +: 8] <= I_BUS.wdata;
          end
        end
        for (int k = 0; k < CHANNELS; k++) begin
          if (I_BUS.addr == 8'(int'(`REG_DUTY_BASE) + k)) begin
            duty_reg[k] <= I_BUS.wdata;
          end
        end
      end
    end
  end

  // Read multiplexer, unmapped reads give zero
  always_comb begin
    rd_next = 8'h00;
    if (I_BUS.addr == `REG_SECOND_MODE_REGISTER) begin
      rd_next[`SECOND_MODE_REGISTER_OVERHEAT] = overheat_f;
      rd_next[`SECOND_MODE_REGISTER_FAULT]    = |fault_reg;
      rd_next[`SECOND_MODE_REGISTER_DIMBLK]   = dimblk_reg;
    end
    if (I_BUS.addr == `REG_GROUP_DUTY) begin
      rd_next = gduty_reg;
    end
    if (I_BUS.addr == `REG_GROUP_PERIOD) begin
      rd_next = gperiod_reg;
    end
    for (int k = 0; k < CHANNELS / 4; k++) begin
      if (I_BUS.addr == 8'(int'(`REG_LDR_BASE) + k)) begin
        rd_next = ldr_reg[8*k +: 8];
      end
      if (I_BUS.addr == 8'(int'(`REG_FAULT_BASE) + k)) begin
        rd_next = fault_reg[8*k +: 8];
      end
    end
    for (int k = 0; k < CHANNELS; k++) begin
      if (I_BUS.addr == 8'(int'(`REG_DUTY_BASE) + k)) begin
        rd_next = duty_reg[k];
      end
    end
  end

  // Read data for one cycle after the strobe
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      O_RDATA <= 8'h00;
    end else if (I_CLK_EN) begin
      O_RDATA <= I_BUS.read ? rd_next : 8'h00;
    end
  end

  // ========================================================================
  // Fast PWM time base and group dimming or blinking counters
  logic [11:0] fast_reg;
  logic [7:0]  gdim_reg;
  logic [10:0] blink_pre_reg;
  logic [7:0]  blink_reg;
  logic        group_on;

  assign group_on = dimblk_reg ? (blink_reg < gduty_reg)
                               : (gdim_reg < gduty_reg);

  // One fast period is 256 steps; group steps count fast periods
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      fast_reg      <= 12'h000;
      gdim_reg      <= 8'h00;
      blink_pre_reg <= 11'h000;
      blink_reg     <= 8'h00;
    end else if (I_CLK_EN) begin
      if (fast_reg == 12'(FAST - 1)) begin
        fast_reg <= 12'h000;
        gdim_reg <= gdim_reg + 8'h01;
        if (blink_pre_reg == {gperiod_reg, 3'h7}) begin
          blink_pre_reg <= 11'h000;
          blink_reg     <= blink_reg + 8'h01;
        end else begin
          blink_pre_reg <= blink_pre_reg + 11'h001;
        end
      end else begin
        fast_reg <= fast_reg + 12'h001;
      end
    end
  end

  // ========================================================================
  // Per channel drive and fault code
  logic [CHANNELS-1:0] want_on;
  logic [CHANNELS-1:0] chk;

  for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
    logic       indiv_on;
    logic [1:0] mode;
    logic       pwm_skip;

    assign mode     = ldr_reg[2*i +: 2];
    assign indiv_on = (duty_reg[i] == `DUTY_FULL) ||
                      ({fast_reg, 1'b0} <
                       13'(duty_reg[i]) * 13'(STEP_X2));
    assign pwm_skip = mode[1] && (duty_reg[i] < `DUTY_MIN_CHECK ||
                                  duty_reg[i] == `DUTY_FULL);
    assign want_on[i] = (mode == 2'h1) || (mode == 2'h2 && indiv_on) ||
                        (mode == 2'h3 && indiv_on && group_on);
    assign chk[i] = O_LED_ON[i] && !pwm_skip;

    // Short wins over open, so code 11 cannot arise
    always_ff @(posedge I_CLOCK or posedge I_RESET) begin
      if (I_RESET) begin
        fault_reg[2*i +: 2] <= `CODE_NONE;
      end else if (I_CLK_EN) begin
        if (soft_clr) begin
          fault_reg[2*i +: 2] <= `CODE_NONE;
        end else if (chk[i] && short_f[i]) begin
          fault_reg[2*i +: 2] <= `CODE_SHORT;
        end else if (chk[i] && open_f[i]) begin
          fault_reg[2*i +: 2] <= `CODE_OPEN;
        end else if (chk[i] && fault_reg[2*i +: 2] == `CODE_SHORT) begin
          fault_reg[2*i +: 2] <= `CODE_NONE;
        end else if (clr_req) begin
          fault_reg[2*i +: 2] <= `CODE_NONE;
        end
      end
    end

    property p_short_code;
      @(posedge I_CLOCK) disable iff (I_RESET)
      (I_CLK_EN && !soft_clr && chk[i] && short_f[i])
        |=> (fault_reg[2*i +: 2] == `CODE_SHORT);
    endproperty
    a_short_code: assert property (p_short_code)
      else $error("short not reported");

    property p_code_legal;
      @(posedge I_CLOCK) disable iff (I_RESET)
      (fault_reg[2*i +: 2] != 2'h3) and
      ((chk[i] && !short_f[i] && I_CLK_EN && !soft_clr)
        |=> (fault_reg[2*i +: 2] != `CODE_SHORT));
    endproperty
    a_code_legal: assert property (p_code_legal)
      else $error("illegal or stale short code");
  end

  // ========================================================================
  // Output gating by enable pin and overheat
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      O_LED_ON  <= '0;
      O_LED_HIZ <= 1'b1;
    end else if (I_CLK_EN) begin
      O_LED_ON  <= want_on & {CHANNELS{!oe_n_f && !overheat_f}};
      O_LED_HIZ <= oe_n_f;
    end
  end

  // ========================================================================
  // Checks
  sequence s_armed_stop;
    I_CLK_EN && gc_state_reg == led_fault_pkg::GC_ARMED && bus_stop;
  endsequence

  sequence s_defaults;
    ldr_reg == '0 && gduty_reg == 8'h00 && !dimblk_reg && !O_READY;
  endsequence

  property p_soft_reset_call;
    @(posedge I_CLOCK) disable iff (I_RESET)
    s_armed_stop |=> s_defaults;
  endproperty
  a_soft_reset_call: assert property (p_soft_reset_call)
    else $error("soft reset call did not clear registers");

  property p_abort;
    @(posedge I_CLOCK) disable iff (I_RESET)
    (I_CLK_EN && bus_stop && gc_state_reg != led_fault_pkg::GC_ARMED &&
     !hw_rst && !I_BUS.write) |=> $stable(ldr_reg) && $stable(gduty_reg);
  endproperty
  a_abort: assert property (p_abort)
    else $error("malformed call changed registers");

  property p_addr_nack;
    @(posedge I_CLOCK) disable iff (I_RESET)
    (I_CLK_EN && byte_done && gc_state_reg == led_fault_pkg::GC_ADDR &&
     gc_shift_reg != `GC_ADDR_BYTE && !bus_stop && !bus_start && !hw_rst)
      |=> !O_SDA_OE ##1 !O_SDA_OE;
  endproperty
  a_addr_nack: assert property (p_addr_nack)
    else $error("foreign address acknowledged");

  property p_data_ack;
    @(posedge I_CLOCK) disable iff (I_RESET)
    (I_CLK_EN && byte_done && gc_state_reg == led_fault_pkg::GC_DATA &&
     !bus_stop && !bus_start && !hw_rst)
      |=> (O_SDA_OE == ($past(gc_shift_reg) == `SOFT_RESET_CALL_BYTE));
  endproperty
  a_data_ack: assert property (p_data_ack)
    else $error("data byte acknowledge wrong");

  property p_extra_nack;
    @(posedge I_CLOCK) disable iff (I_RESET)
    (I_CLK_EN && byte_done && gc_state_reg == led_fault_pkg::GC_ARMED &&
     !bus_stop && !bus_start && !hw_rst)
      |=> !O_SDA_OE && gc_state_reg == led_fault_pkg::GC_IGNORE;
  endproperty
  a_extra_nack: assert property (p_extra_nack)
    else $error("extra byte acknowledged");

  property p_gate_off;
    @(posedge I_CLOCK) disable iff (I_RESET)
    (I_CLK_EN && (oe_n_f || overheat_f)) |=> (O_LED_ON == '0);
  endproperty
  a_gate_off: assert property (p_gate_off)
    else $error("output on while disabled");

  property p_hiz;
    @(posedge I_CLOCK) disable iff (I_RESET)
    I_CLK_EN |=> (O_LED_HIZ == $past(oe_n_f));
  endproperty
  a_hiz: assert property (p_hiz)
    else $error("high impedance not following enable pin");

  property p_status;
    @(posedge I_CLOCK) disable iff (I_RESET)
    (I_CLK_EN && I_BUS.read && I_BUS.addr == `REG_SECOND_MODE_REGISTER)
      |=> O_RDATA[7:6] == {$past(overheat_f), $past(|fault_reg)};
  endproperty
  a_status: assert property (p_status)
    else $error("mode register status bits wrong");

endmodule

//--- core/led_fault_params.svh
`ifndef LED_FAULT_PARAMS_SVH
`define LED_FAULT_PARAMS_SVH

// ==========================================================================
// Register offsets and fields
`define NUM_CHANNELS      16
`define REG_SECOND_MODE_REGISTER         8'h00
`define REG_GROUP_DUTY    8'h01
`define REG_GROUP_PERIOD  8'h02
`define REG_LDR_BASE      8'h04
`define REG_DUTY_BASE     8'h08
`define REG_FAULT_BASE    8'h18
`define SECOND_MODE_REGISTER_OVERHEAT    7
`define SECOND_MODE_REGISTER_FAULT       6
`define SECOND_MODE_REGISTER_DIMBLK      5
`define SECOND_MODE_REGISTER_CLR_FAULT   4
`define GC_ADDR_BYTE      8'h00
`define SOFT_RESET_CALL_BYTE        8'h06
`define CODE_NONE         2'h0
`define CODE_SHORT        2'h1
`define CODE_OPEN         2'h2
`define DUTY_MIN_CHECK    8'h08
`define DUTY_FULL         8'hFF

// ==========================================================================
// Timing
`define CLK_PERIOD_NS     10
`define POR_WAKE_NS       2000000
`define HW_WAKE_NS        1500000
`define SW_WAKE_NS        1000000
`define RST_PULSE_NS      2500
`define FAST_PWM_NS       32000
`define POR_WAKE_CYC      (`POR_WAKE_NS / `CLK_PERIOD_NS)
`define HW_WAKE_CYC       (`HW_WAKE_NS / `CLK_PERIOD_NS)
`define SW_WAKE_CYC       (`SW_WAKE_NS / `CLK_PERIOD_NS)
`define RST_MIN_CYC       ((`RST_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FAST_PWM_CYC      (`FAST_PWM_NS / `CLK_PERIOD_NS)

`endif

//--- core/led_fault_pkg.sv
package led_fault_pkg;

  // ========================================================================
  // General call receiver states
  typedef enum logic [2:0] {
    GC_IDLE,
    GC_ADDR,
    GC_DATA,
    GC_ARMED,
    GC_IGNORE
  } gc_state_t;

  // ========================================================================
  // Register request from software
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       write;
    logic       read;
  } bus_req_t;

endpackage

//--- verif/gc_master.sv
`timescale 1ns/10ps
// ==========================================================================
// Bus master sending the reset call on a pulled-up data wire
module gc_master (
  input  wire logic i_clk,
  input  wire logic i_sda_oe,
  output logic      o_scl,
  output logic      o_sda
);
  logic sda_drv;

  // Pull-up level unless a party pulls the wire low
  assign o_sda = sda_drv & ~i_sda_oe;

  // Idle bus, both lines high
  initial begin
    o_scl = 1'b1;
    sda_drv = 1'b1;
  end

  // Third of a bit wait
  task automatic hb();
    repeat (10) @(posedge i_clk);
  endtask

  // One clock pulse; data moves only while the clock is low
  task automatic pulse(input logic v, output logic s);
    sda_drv <= v;
    hb();
    o_scl <= 1'b1;
    hb();
    s = o_sda;
    o_scl <= 1'b0;
    hb();
  endtask

  // Start or repeated start
  task automatic start();
    sda_drv <= 1'b1;
    hb();
    o_scl <= 1'b1;
    hb();
    sda_drv <= 1'b0;
    hb();
    o_scl <= 1'b0;
    hb();
  endtask

  // Byte MSB first, then an ack clock with data released
  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      pulse(b[i], s);
    end
    pulse(1'b1, s);
    ack = ~s;
  endtask

  // Stop closes the call
  task automatic stop();
    sda_drv <= 1'b0;
    hb();
    o_scl <= 1'b1;
    hb();
    sda_drv <= 1'b1;
    @(posedge i_clk);
  endtask
endmodule

//--- verif/test_led_fault_ctrl.sv
`timescale 1ns/10ps
// ==========================================================================
// Bench for the fault and reset control block
module test_led_fault_ctrl;
  logic                    clk, rst, oe_n, pin_n, hot, scl, sda, sda_oe;
  logic                    hiz, ready, ack;
  logic [7:0]              rdata;
  logic [15:0]             opn, shrt, led_on;
  int                      num_errors, cmp_count;
  led_fault_pkg::bus_req_t bus;

  // Block with short wake counts
  led_fault_ctrl #(.POR_WAKE_CYC(20), .HW_WAKE_CYC(15), .SW_WAKE_CYC(10))
  u_led_fault_ctrl (
    .I_CLOCK(clk),
    .I_RESET(rst),
    .I_CLK_EN(1'b1),
    .I_BUS(bus),
    .O_RDATA(rdata),
    .I_OE_N(oe_n),
    .I_RESET_PIN_N(pin_n),
    .I_OVERHEAT(hot),
    .I_SCL(scl),
    .I_SDA(sda),
    .I_OPEN(opn),
    .I_SHORT(shrt),
    .O_SDA_OUT(),
    .O_SDA_OE(sda_oe),
    .O_LED_ON(led_on),
    .O_LED_HIZ(hiz),
    .O_READY(ready)
  );

  // Far side bus master
  gc_master u_gc_master (
    .i_clk(clk),
    .i_sda_oe(sda_oe),
    .o_scl(scl),
    .o_sda(sda)
  );

  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Compare and count
  task automatic check(input logic [15:0] s, e);
    cmp_count++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  // Verdict and end of run
  task automatic give_verdict();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Register bus cycles
  task automatic wr(input logic [7:0] a, d);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, e);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
    check(rdata, e);
  endtask

  // Waits
  task automatic w8();
    repeat (8) @(posedge clk);
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    check(n < 300, 1);
    if (n >= 300) give_verdict();
  endtask

  // Main sequence
  initial begin
    {rst, oe_n, pin_n, hot, opn, shrt, bus} = '0;
    rst = 1'b1;
    oe_n = 1'b1;
    pin_n = 1'b1;
    repeat (3) @(posedge clk);
    check(hiz, 1);
    check(ready, 0);
    rst <= 1'b0;
    wait_rdy();
    rd(8'h00, 8'h00);
    wr(8'h04, 8'h21);
    wr(8'h0A, 8'h04);
    wr(8'h00, 8'h20); // DIMBLK set, group blinking
    oe_n <= 1'b0;
    w8();
    check(led_on[0], 1);
    check(hiz, 0);
    shrt <= 16'h0001;
    w8();
    rd(8'h18, 8'h01);
    rd(8'h00, 8'h60);
    shrt <= 16'h0000;
    w8();
    rd(8'h18, 8'h00);
    opn <= 16'h0007;
    repeat (3300) @(posedge clk);
    rd(8'h18, 8'h02);
    wr(8'h0A, 8'h08);
    repeat (3300) @(posedge clk);
    rd(8'h18, 8'h22);
    opn <= 16'h0000;
    wr(8'h04, 8'h01); // faulty channel 2 off, faulty channel 0 left on
    rd(8'h18, 8'h22);
    wr(8'h00, 8'h30);
    rd(8'h18, 8'h00);
    hot <= 1'b1;
    w8();
    check(led_on, 0);
    rd(8'h00, 8'hA0);
    hot <= 1'b0;
    w8();
    check(led_on[0], 1);
    rd(8'h00, 8'h20);
    oe_n <= 1'b1;
    w8();
    check(hiz, 1);
    u_gc_master.start();
    u_gc_master.send(8'h01, ack);
    check(ack, 0);
    u_gc_master.start();
    u_gc_master.send(8'h00, ack);
    check(ack, 1);
    u_gc_master.send(8'h07, ack);
    check(ack, 0);
    u_gc_master.stop();
    rd(8'h00, 8'h20);
    u_gc_master.start();
    u_gc_master.send(8'h00, ack);
    u_gc_master.send(8'h06, ack);
    check(ack, 1);
    u_gc_master.send(8'h06, ack);
    check(ack, 0);
    u_gc_master.start();
    u_gc_master.send(8'h00, ack);
    u_gc_master.send(8'h06, ack);
    u_gc_master.stop();
    w8();
    check(ready, 0);
    rd(8'h00, 8'h00);
    rd(8'h04, 8'h00);
    wait_rdy();
    wr(8'h00, 8'h20);
    pin_n <= 1'b0;
    repeat (100) @(posedge clk);
    pin_n <= 1'b1;
    w8();
    rd(8'h00, 8'h20);
    pin_n <= 1'b0;
    repeat (270) @(posedge clk);
    pin_n <= 1'b1;
    check(ready, 0);
    rd(8'h00, 8'h00);
    wait_rdy();
    give_verdict();
  end
endmodule
